// file: hw/tcq_qualifier.sv
// Purpose: qualifies event counts by logical thread and privilege, plus clocktick counters
// Assumes: thread state and event inputs come from core logic on i_mclk;
//          i_ref_tick comes from a fixed reference clock domain
// Notes:   one programmable counter, one time-stamp counter, one reference counter
`timescale 1ns/10ps

// Operation
// - logical thread id is bit 0 of the slot's local interrupt controller id
// - each event mask bit is classed per-thread or shared by a register
// - a per-thread event counts only by its own thread's flags
// - per-thread events count while owner thread runs at an enabled class
// - shared events use merged classes of both threads; both classes means always
// - programmable and reference counters stay powered unless both logical threads are halted
// - time-stamp counter stops in deep sleep only
// - non-halted ticks count per thread when not halted nor power saving
// - non-sleep ticks count while the package is not asleep, no thread filter
// - time-stamp counter counts every non deep sleep cycle, no thread filter
// - clocktick counter overflow may raise the sampling interrupt
// - reference ticks count at fixed reference rate, not core ratio
// - kernel flag counts only at privilege level zero
// - user flag counts only at privilege levels one to three
// - counter enable is cleared by reset
module tcq_qualifier #(
   parameter int unsigned EVM_W = tcq_pkg::EVM_W,
   parameter int unsigned CNT_W = tcq_pkg::CNT_W
) (
   input  wire logic                       i_mclk,
   input  wire logic                       i_srst,
   // register port
   input  wire logic [tcq_pkg::ADDR_W-1:0] i_addr,
   input  wire logic [tcq_pkg::DATA_W-1:0] i_wdata,
   input  wire logic                       i_wr,
   input  wire logic                       i_rd,
   output logic [tcq_pkg::DATA_W-1:0]      o_rdata,
   // core state
   input  wire tcq_pkg::tcq_thr_t          i_thr_a,
   input  wire tcq_pkg::tcq_thr_t          i_thr_b,
   input  wire logic [EVM_W-1:0]           i_evt_a,
   input  wire logic [EVM_W-1:0]           i_evt_b,
   input  wire logic [EVM_W-1:0]           i_evt_shared,
   input  wire logic                       i_pkg_sleep,
   input  wire logic                       i_deep_sleep,
   input  wire logic                       i_ref_tick,
   // results
   output logic                            o_cnt_inc,
   output logic                            o_pmc_powered,
   output logic                            o_irq
);

   // ---------------------------------------------------------------- registers
   logic [31:0]                  evsel_ff;
   logic [31:0]                  ccfg_ff;
   logic [EVM_W-1:0]             shcls_ff;
   logic [tcq_pkg::STAT_W-1:0]   stat_ff;
   logic [tcq_pkg::STAT_W-1:0]   mask_ff;
   logic [tcq_pkg::DATA_W-1:0]   rdata_ff;
   logic                         irq_ff;
   logic                         cnt_inc_ff;
   logic                         powered_ff;
   logic [tcq_pkg::SYNC_DEPTH-1:0] ref_sync_ff;
   logic                         ref_last_ff;

   logic                         wr_evsel;
   logic                         wr_ccfg;
   logic                         wr_shcls;
   logic                         wr_cnt;
   logic                         wr_mask;
   logic                         rd_stat;

   assign wr_evsel = i_wr && (i_addr == tcq_pkg::OFF_EVSEL);
   assign wr_ccfg  = i_wr && (i_addr == tcq_pkg::OFF_CCFG);
   assign wr_shcls = i_wr && (i_addr == tcq_pkg::OFF_SHCLS);
   assign wr_cnt   = i_wr && (i_addr == tcq_pkg::OFF_CNT);
   assign wr_mask  = i_wr && (i_addr == tcq_pkg::OFF_MASK);
   assign rd_stat  = i_rd && (i_addr == tcq_pkg::OFF_STAT);

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         evsel_ff <= tcq_pkg::EVSEL_RST;
      end else if (wr_evsel) begin
         evsel_ff <= i_wdata;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         ccfg_ff <= tcq_pkg::CCFG_RST;
      end else if (wr_ccfg) begin
         ccfg_ff <= i_wdata;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         shcls_ff <= tcq_pkg::SHCLS_RST;
      end else if (wr_shcls) begin
         shcls_ff <= i_wdata[EVM_W-1:0];
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         mask_ff <= tcq_pkg::MASK_RST;
      end else if (wr_mask) begin
         mask_ff <= i_wdata[tcq_pkg::STAT_W-1:0];
      end
   end

   // ---------------------------------------------------------- field decode
   logic [EVM_W-1:0]      ev_mask;
   logic                  cnt_en;
   logic                  pmi_en;
   tcq_pkg::tcq_mode_t    mode;
   tcq_pkg::tcq_qual_t    q0;
   tcq_pkg::tcq_qual_t    q1;

   assign ev_mask = evsel_ff[tcq_pkg::EVS_MASK_LSB +: EVM_W];
   assign cnt_en  = ccfg_ff[tcq_pkg::CCFG_EN];
   assign pmi_en  = ccfg_ff[tcq_pkg::CCFG_PMI_EN];
   assign mode    = tcq_pkg::tcq_mode_t'(ccfg_ff[tcq_pkg::CCFG_MODE_LSB +: tcq_pkg::CCFG_MODE_W]);
   assign q0      = '{kernel_enable: evsel_ff[tcq_pkg::EVS_T0_KERN],
                      user_enable:   evsel_ff[tcq_pkg::EVS_T0_USER]};
   assign q1      = '{kernel_enable: evsel_ff[tcq_pkg::EVS_T1_KERN],
                      user_enable:   evsel_ff[tcq_pkg::EVS_T1_USER]};

   // ------------------------------------------------ slot to logical thread
   // slot b is taken as the other thread; equal ids would be a core fault
   logic                  a_is_t1;
   tcq_pkg::tcq_thr_t     thr0;
   tcq_pkg::tcq_thr_t     thr1;
   logic [EVM_W-1:0]      evt0;
   logic [EVM_W-1:0]      evt1;

   assign a_is_t1 = i_thr_a.local_intr_ctrl_id[0];
   assign thr0    = a_is_t1 ? i_thr_b : i_thr_a;
   assign thr1    = a_is_t1 ? i_thr_a : i_thr_b;
   assign evt0    = a_is_t1 ? i_evt_b : i_evt_a;
   assign evt1    = a_is_t1 ? i_evt_a : i_evt_b;

   // ------------------------------------------------- privilege classing
   logic t0_kern;
   logic t0_user;
   logic t1_kern;
   logic t1_user;

   assign t0_kern = (thr0.current_privilege == tcq_pkg::CPL_KERNEL);
   assign t0_user = !t0_kern;
   assign t1_kern = (thr1.current_privilege == tcq_pkg::CPL_KERNEL);
   assign t1_user = !t1_kern;

   // each thread judged only by its own flags
   logic t0_qual;
   logic t1_qual;

   assign t0_qual = (q0.kernel_enable && t0_kern) || (q0.user_enable && t0_user);
   assign t1_qual = (q1.kernel_enable && t1_kern) || (q1.user_enable && t1_user);

   // shared events: classes merged over both threads
   logic mrg_kern;
   logic mrg_user;
   logic sh_qual;

   assign mrg_kern = q0.kernel_enable || q1.kernel_enable;
   assign mrg_user = q0.user_enable || q1.user_enable;
   assign sh_qual  = (mrg_kern && mrg_user) ||
                     (mrg_kern && (t0_kern || t1_kern)) ||
                     (mrg_user && (t0_user || t1_user));

   // --------------------------------------------------- event qualification
   logic [EVM_W-1:0] pt_hits;
   logic [EVM_W-1:0] sh_hits;
   logic             evt_qual;

   // per-thread bits see thread events, shared bits see the shared source
   assign pt_hits  = ev_mask & ~shcls_ff &
                     ((evt0 & {EVM_W{t0_qual}}) | (evt1 & {EVM_W{t1_qual}}));
   assign sh_hits  = ev_mask & shcls_ff & i_evt_shared & {EVM_W{sh_qual}};
   // several hits in one cycle still give one count
   assign evt_qual = |(pt_hits | sh_hits);

   // ------------------------------------------------------ clocktick modes
   logic run0;
   logic run1;
   logic powered;
   logic mode_inc;

   assign run0    = !thr0.halted && !thr0.psave;
   assign run1    = !thr1.halted && !thr1.psave;
   assign powered = !(thr0.halted && thr1.halted);

   always_comb begin
      unique case (mode)
         tcq_pkg::TCQ_MODE_EVENT:    mode_inc = evt_qual;
         tcq_pkg::TCQ_MODE_NH_T0:    mode_inc = run0 && t0_qual;
         tcq_pkg::TCQ_MODE_NH_T1:    mode_inc = run1 && t1_qual;
         tcq_pkg::TCQ_MODE_NONSLEEP: mode_inc = !i_pkg_sleep;
         default:                    mode_inc = 1'b0;
      endcase
   end

   // powered-down counters hold their value
   logic cnt_inc;

   assign cnt_inc = cnt_en && powered && mode_inc;

   // ------------------------------------------------ reference tick input
   // first stage feeds only the second; edge seen between stage two and last
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         ref_sync_ff <= '0;
         ref_last_ff <= 1'b0;
      end else begin
         ref_sync_ff <= {ref_sync_ff[tcq_pkg::SYNC_DEPTH-2:0], i_ref_tick};
         ref_last_ff <= ref_sync_ff[tcq_pkg::SYNC_DEPTH-1];
      end
   end

   logic ref_inc;

   // core ratio changes do not touch this path: it follows the reference edge
   assign ref_inc = ref_sync_ff[tcq_pkg::SYNC_DEPTH-1] && !ref_last_ff && powered;

   logic tsc_inc;

   assign tsc_inc = !i_deep_sleep;

   // ------------------------------------------------------------- counters
   logic [CNT_W-1:0] cnt_val;
   logic [CNT_W-1:0] tsc_val;
   logic [CNT_W-1:0] ref_val;
   logic             cnt_wrap;
   logic             tsc_wrap;
   logic             ref_wrap;

   tcq_counter #(.W(CNT_W)) u_cnt (
      .i_mclk  (i_mclk),
      .i_srst  (i_srst),
      .i_clr   (wr_cnt),
      .i_inc   (cnt_inc),
      .o_value (cnt_val),
      .o_wrap  (cnt_wrap)
   );

   tcq_counter #(.W(CNT_W)) u_tsc (
      .i_mclk  (i_mclk),
      .i_srst  (i_srst),
      .i_clr   (1'b0),
      .i_inc   (tsc_inc),
      .o_value (tsc_val),
      .o_wrap  (tsc_wrap)
   );

   tcq_counter #(.W(CNT_W)) u_ref (
      .i_mclk  (i_mclk),
      .i_srst  (i_srst),
      .i_clr   (1'b0),
      .i_inc   (ref_inc),
      .o_value (ref_val),
      .o_wrap  (ref_wrap)
   );

   // --------------------------------------------------- status and interrupt
   logic [tcq_pkg::STAT_W-1:0] stat_set;
   logic [tcq_pkg::STAT_W-1:0] nxt_stat;

   always_comb begin
      stat_set                        = '0;
      stat_set[tcq_pkg::STAT_CNT_OVF] = cnt_wrap && pmi_en;
      stat_set[tcq_pkg::STAT_REF_OVF] = ref_wrap;
      stat_set[tcq_pkg::STAT_TSC_OVF] = tsc_wrap;
      // a set in the clearing read cycle survives
      nxt_stat = (rd_stat ? '0 : stat_ff) | stat_set;
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         stat_ff <= tcq_pkg::STAT_RST;
      end else begin
         stat_ff <= nxt_stat;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(nxt_stat & mask_ff);
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         cnt_inc_ff <= 1'b0;
         powered_ff <= 1'b0;
      end else begin
         cnt_inc_ff <= cnt_inc;
         powered_ff <= powered;
      end
   end

   // ------------------------------------------------------------ read path
   logic [tcq_pkg::DATA_W-1:0] rd_mux;

   always_comb begin
      rd_mux = '0;
      unique case (i_addr)
         tcq_pkg::OFF_EVSEL:  rd_mux = evsel_ff;
         tcq_pkg::OFF_CCFG:   rd_mux = ccfg_ff;
         tcq_pkg::OFF_SHCLS:  rd_mux[EVM_W-1:0] = shcls_ff;
         tcq_pkg::OFF_CNT:    rd_mux[CNT_W-1:0] = cnt_val;
         tcq_pkg::OFF_TSC:    rd_mux[CNT_W-1:0] = tsc_val;
         tcq_pkg::OFF_REFCNT: rd_mux[CNT_W-1:0] = ref_val;
         tcq_pkg::OFF_STAT:   rd_mux[tcq_pkg::STAT_W-1:0] = stat_ff;
         tcq_pkg::OFF_MASK:   rd_mux[tcq_pkg::STAT_W-1:0] = mask_ff;
         tcq_pkg::OFF_INFO:   rd_mux[3:0] = {a_is_t1, run1, run0, powered};
         default:             rd_mux = '0;
      endcase
   end

   // data valid only in the cycle after the read strobe
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         rdata_ff <= '0;
      end else begin
         rdata_ff <= i_rd ? rd_mux : '0;
      end
   end

   assign o_rdata       = rdata_ff;
   assign o_irq         = irq_ff;
   assign o_cnt_inc     = cnt_inc_ff;
   assign o_pmc_powered = powered_ff;

endmodule

// file: hw/tcq_pkg.sv
// Purpose: shared constants and types of the thread and privilege event qualifier
// Assumes: one core clock, software register port with byte addresses
// Notes:   field positions of the event select and counter config words live here
package tcq_pkg;

   localparam int unsigned DATA_W     = 32;
   localparam int unsigned ADDR_W     = 8;
   localparam int unsigned EVM_W      = 16;
   localparam int unsigned CNT_W      = 32;
   localparam int unsigned SYNC_DEPTH = 2;

   // register byte addresses
   localparam logic [7:0] OFF_EVSEL  = 8'h00;
   localparam logic [7:0] OFF_CCFG   = 8'h04;
   localparam logic [7:0] OFF_SHCLS  = 8'h08;
   localparam logic [7:0] OFF_CNT    = 8'h0C;
   localparam logic [7:0] OFF_TSC    = 8'h10;
   localparam logic [7:0] OFF_REFCNT = 8'h14;
   localparam logic [7:0] OFF_STAT   = 8'h18;
   localparam logic [7:0] OFF_MASK   = 8'h1C;
   localparam logic [7:0] OFF_INFO   = 8'h20;

   // event_select_register fields
   localparam int unsigned EVS_T1_USER  = 0;
   localparam int unsigned EVS_T1_KERN  = 1;
   localparam int unsigned EVS_T0_USER  = 2;
   localparam int unsigned EVS_T0_KERN  = 3;
   localparam int unsigned EVS_MASK_LSB = 9;
   localparam int unsigned EVS_SEL_LSB  = 25;
   localparam int unsigned EVS_SEL_W    = 6;

   // counter_config_register fields
   localparam int unsigned CCFG_MODE_LSB = 0;
   localparam int unsigned CCFG_MODE_W   = 3;
   localparam int unsigned CCFG_EN       = 12;
   localparam int unsigned CCFG_PMI_EN   = 26;

   // status / mask bits
   localparam int unsigned STAT_CNT_OVF = 0;
   localparam int unsigned STAT_REF_OVF = 1;
   localparam int unsigned STAT_TSC_OVF = 2;
   localparam int unsigned STAT_W       = 3;

   // reset values
   localparam logic [31:0]       EVSEL_RST = 32'h0000_0000;
   localparam logic [31:0]       CCFG_RST  = 32'h0000_0000;
   localparam logic [EVM_W-1:0]  SHCLS_RST = 16'h0000;
   localparam logic [STAT_W-1:0] STAT_RST  = 3'h0;
   localparam logic [STAT_W-1:0] MASK_RST  = 3'h0;

   localparam logic [1:0] CPL_KERNEL = 2'h0;

   typedef enum logic [CCFG_MODE_W-1:0] {
      TCQ_MODE_EVENT,
      TCQ_MODE_NH_T0,
      TCQ_MODE_NH_T1,
      TCQ_MODE_NONSLEEP
   } tcq_mode_t;

   // state of one hardware thread slot as the core reports it
   typedef struct packed {
      logic       halted;
      logic       psave;
      logic [1:0] current_privilege;
      logic [7:0] local_intr_ctrl_id;
   } tcq_thr_t;

   // privilege qualification flags of one logical thread
   typedef struct packed {
      logic kernel_enable;
      logic user_enable;
   } tcq_qual_t;

endpackage

// file: hw/tcq_counter.sv
// Purpose: free running counter with clear and one-cycle wrap pulse
// Assumes: at most one increment per clock
// Notes:   wrap pulse is registered, one cycle after the increment that wraps
`timescale 1ns/10ps
module tcq_counter #(
   parameter int unsigned W = 32
) (
   input  wire logic         i_mclk,
   input  wire logic         i_srst,
   input  wire logic         i_clr,
   input  wire logic         i_inc,
   output logic [W-1:0]      o_value,
   output logic              o_wrap
);

   logic [W-1:0] value_ff;
   logic         wrap_ff;

   always_ff @(posedge i_mclk) begin
      if (i_srst || i_clr) begin
         value_ff <= '0;
      end else if (i_inc) begin
         value_ff <= value_ff + W'(1);
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         wrap_ff <= 1'b0;
      end else begin
         wrap_ff <= i_inc && !i_clr && (&value_ff);
      end
   end

   assign o_value = value_ff;
   assign o_wrap  = wrap_ff;

endmodule

// file: tb/tcq_qualifier_assertions.sv
// Purpose: port-level checks of the thread and privilege qualifier
// Assumes: one core clock, synchronous reset
// Notes:   readback checks need a write followed at once by a read
`timescale 1ns/10ps
module tcq_qualifier_assertions #(
   parameter int unsigned EVM_W = tcq_pkg::EVM_W,
   parameter int unsigned CNT_W = tcq_pkg::CNT_W
) (
   input wire logic                       i_mclk,
   input wire logic                       i_srst,
   input wire logic [tcq_pkg::ADDR_W-1:0] i_addr,
   input wire logic [tcq_pkg::DATA_W-1:0] i_wdata,
   input wire logic                       i_wr,
   input wire logic                       i_rd,
   input wire logic [tcq_pkg::DATA_W-1:0] o_rdata,
   input wire tcq_pkg::tcq_thr_t          i_thr_a,
   input wire tcq_pkg::tcq_thr_t          i_thr_b,
   input wire logic                       o_cnt_inc,
   input wire logic                       o_pmc_powered
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_srst);
   wire both_halted = i_thr_a.halted && i_thr_b.halted;
   wire slot_a_odd  = i_thr_a.local_intr_ctrl_id[0];
   sequence wr_rd(logic [7:0] a);
      i_wr && i_addr == a ##1 i_rd && i_addr == a;
   endsequence
   // thread state held so a registered copy cannot lag the answer
   sequence info_rd;
      i_rd && i_addr == tcq_pkg::OFF_INFO && $stable(i_thr_a) && $stable(i_thr_b);
   endsequence
   chk_rdata_idle: assert property (
      !$past(i_rd) |-> o_rdata == '0) else $error("read data not zero outside answer");
   chk_power_gate: assert property (
      !$past(i_srst) |-> o_pmc_powered == !$past(both_halted))
      else $error("power flag wrong for halt state");
   chk_inc_refused: assert property (
      o_cnt_inc |-> !($past(both_halted) && $past(both_halted, 2)))
      else $error("increment while both threads halted");
   chk_info_slot: assert property (
      info_rd |=> o_rdata[3] == $past(slot_a_odd)) else $error("slot thread id wrong");
   chk_info_power: assert property (
      info_rd |=> o_rdata[0] == !$past(both_halted)) else $error("info power bit wrong");
   chk_unmapped_zero: assert property (
      i_rd && i_addr >= 8'h24 |=> o_rdata == '0) else $error("unmapped read not zero");
   chk_class_back: assert property (
      wr_rd(tcq_pkg::OFF_SHCLS) |=> o_rdata[15:0] == $past(i_wdata[15:0], 2)
      && o_rdata[31:16] == '0) else $error("class readback wrong");
   chk_evsel_back: assert property (
      wr_rd(tcq_pkg::OFF_EVSEL) |=> (o_rdata & 32'h7FFF_FE0F) == ($past(i_wdata, 2)
      & 32'h7FFF_FE0F)) else $error("select readback wrong");
   chk_mask_back: assert property (
      wr_rd(tcq_pkg::OFF_MASK) |=> o_rdata[2:0] == $past(i_wdata[2:0], 2))
      else $error("mask readback wrong");
   chk_clear_wins: assert property (
      wr_rd(tcq_pkg::OFF_CNT) |=> o_rdata <= 32'h1) else $error("counter clear lost");
endmodule
bind tcq_qualifier tcq_qualifier_assertions #(.EVM_W(EVM_W), .CNT_W(CNT_W)) u_chk (
   .i_mclk(i_mclk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
   .i_rd(i_rd), .o_rdata(o_rdata), .i_thr_a(i_thr_a), .i_thr_b(i_thr_b),
   .o_cnt_inc(o_cnt_inc), .o_pmc_powered(o_pmc_powered));

// file: tb/tcq_core_model.sv
// Purpose: stand-in for the core side: thread state, events, sleep, reference tick
// Assumes: outside the go window the core looks idle, so the programmable counter does not count
// Notes:   only event bit 0 is ever raised
`timescale 1ns/10ps
module tcq_core_model (
   input  wire logic         i_mclk,
   input  wire logic         i_go,
   input  wire logic         i_sh,
   input  wire logic         i_id_a,
   input  wire logic         i_halt_a,
   input  wire logic         i_halt_b,
   input  wire logic         i_ps_a,
   input  wire logic         i_sleep,
   input  wire logic         i_deep,
   input  wire logic         i_ref_run,
   input  wire logic [1:0]   i_cpl_a,
   input  wire logic [1:0]   i_cpl_b,
   output tcq_pkg::tcq_thr_t o_thr_a,
   output tcq_pkg::tcq_thr_t o_thr_b,
   output logic [15:0]       o_evt_a,
   output logic [15:0]       o_evt_b,
   output logic [15:0]       o_evt_sh,
   output logic              o_pkg_sleep,
   output logic              o_deep_sleep,
   output logic              o_ref_tick
);
   logic [1:0] ph = 2'h0;
   // slots always carry opposite id bit 0; upper id bits are noise
   assign o_thr_a      = {i_halt_a, i_ps_a | ~i_go, i_cpl_a, 7'h2A, i_id_a};
   assign o_thr_b      = {i_halt_b, ~i_go, i_cpl_b, 7'h55, ~i_id_a};
   assign o_evt_a      = {15'h0, i_go & ~i_sh};
   assign o_evt_b      = 16'h0;
   assign o_evt_sh     = {15'h0, i_go & i_sh};
   assign o_pkg_sleep  = i_sleep | ~i_go;
   assign o_deep_sleep = i_deep;
   initial o_ref_tick = 1'h0;
   always @(posedge i_mclk) begin
      ph <= ph + 2'h1;
      // fixed-rate tick, blind to core ratio and thread state
      if (i_ref_run && ph == 2'h3) begin
         o_ref_tick <= ~o_ref_tick;
      end
   end
endmodule

// file: tb/tcq_qualifier_test.sv
// Purpose: self-checking bench of the thread and privilege qualifier
// Assumes: counter width cut to 8 so a wrap fits in a short run
// Notes:   every write is read straight back, feeding the readback checks
`timescale 1ns/10ps
module tcq_qualifier_test;
   logic              i_mclk  = 1'h0;
   logic              i_srst  = 1'h1;
   logic              i_wr    = 1'h0;
   logic              i_rd    = 1'h0;
   logic [7:0]        i_addr  = 8'h00;
   logic [31:0]       i_wdata = 32'h0;
   logic              go = 1'h0, sh = 1'h0, ida = 1'h0, ha = 1'h0, hb = 1'h0, psa = 1'h0;
   logic              slp = 1'h0, deep = 1'h0, rrun = 1'h0, xpt, k, u, mk, mu;
   logic [1:0]        ca = 2'h0, cb = 2'h0;
   logic [31:0]       d0, d1, o_rdata;
   logic [15:0]       evt_a, evt_b, evt_sh;
   logic              pkg_sleep, deep_sleep, ref_tick, o_cnt_inc, o_pmc_powered, o_irq;
   tcq_pkg::tcq_thr_t thr_a, thr_b;
   int                bad_count = 0, checks_done = 0, cyc = 0;
   // mode, halt a, halt b, power save a, sleep, counts
   logic [7:0]        tk [8] = '{8'h21, 8'h30, 8'h24, 8'h51, 8'h71, 8'h62, 8'h78, 8'hA0};
   always #2 i_mclk = ~i_mclk;
   tcq_core_model core (.i_mclk(i_mclk), .i_go(go), .i_sh(sh), .i_id_a(ida), .i_halt_a(ha),
      .i_halt_b(hb), .i_ps_a(psa), .i_sleep(slp), .i_deep(deep), .i_ref_run(rrun),
      .i_cpl_a(ca), .i_cpl_b(cb), .o_thr_a(thr_a), .o_thr_b(thr_b), .o_evt_a(evt_a),
      .o_evt_b(evt_b), .o_evt_sh(evt_sh), .o_pkg_sleep(pkg_sleep),
      .o_deep_sleep(deep_sleep), .o_ref_tick(ref_tick));
   tcq_qualifier #(.CNT_W(8)) dut (.i_mclk(i_mclk), .i_srst(i_srst), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_thr_a(thr_a),
      .i_thr_b(thr_b), .i_evt_a(evt_a), .i_evt_b(evt_b), .i_evt_shared(evt_sh),
      .i_pkg_sleep(pkg_sleep), .i_deep_sleep(deep_sleep), .i_ref_tick(ref_tick),
      .o_cnt_inc(o_cnt_inc), .o_pmc_powered(o_pmc_powered), .o_irq(o_irq));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      i_rd <= 1'h1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'h0;
      @(posedge i_mclk);
      d = o_rdata;
   endtask
   task automatic wrrd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
      i_wr <= 1'h1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_mclk);
      i_wr <= 1'h0;
      i_rd <= 1'h1;
      @(posedge i_mclk);
      i_rd <= 1'h0;
      @(posedge i_mclk);
      chk(o_rdata, d & m);
   endtask
   // clear, let the core run four cycles, then read the count
   task automatic window(input logic [31:0] exp);
      logic [31:0] d;
      wrrd(tcq_pkg::OFF_CNT, 32'hFFFF_FFFF, 32'h0);
      go <= 1'h1;
      repeat (4) @(posedge i_mclk);
      go <= 1'h0;
      repeat (3) @(posedge i_mclk);
      rd(tcq_pkg::OFF_CNT, d);
      chk(d, exp);
   endtask
   function automatic logic q(input logic kf, input logic uf, input logic [1:0] c);
      return (c == 2'h0) ? kf : uf;
   endfunction
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge i_mclk) begin
      cyc++;
      if (cyc == 12000) begin
         bad_count++;
         report_and_stop();
      end
   end
   initial begin
      repeat (4) @(posedge i_mclk);
      i_srst <= 1'h0;
      @(posedge i_mclk);
      rd(tcq_pkg::OFF_CCFG, d0);
      chk(d0, tcq_pkg::CCFG_RST);
      rd(8'h24, d0);
      chk(d0, 32'h0);
      wrrd(tcq_pkg::OFF_CCFG, 32'h0000_1000, 32'h0400_1007);
      for (int s = 0; s < 2; s++) begin
         sh <= s[0];
         wrrd(tcq_pkg::OFF_SHCLS, {31'h0, s[0]}, 32'hFFFF);
         for (int n = 0; n < 128; n++) begin
            ida <= n[6];
            ca <= {n[1], n[1]};
            cb <= {1'h0, n[0]};
            // mask bit 0 selects the only event the core model raises
            wrrd(tcq_pkg::OFF_EVSEL, {22'h0, 1'h1, 5'h0, n[5:2]}, 32'h7FFF_FE0F);
            k = n[6] ? n[3] : n[5];
            u = n[6] ? n[2] : n[4];
            mk = n[5] | n[3];
            mu = n[4] | n[2];
            if (s == 0) xpt = q(k, u, {n[1], n[1]});
            else xpt = (mk & ~(n[1] & n[0])) | (mu & (n[1] | n[0]));
            window({29'h0, xpt, 2'h0});
         end
      end
      ida <= 1'h0;
      ca <= 2'h0;
      cb <= 2'h0;
      wrrd(tcq_pkg::OFF_EVSEL, 32'hF, 32'h7FFF_FE0F);
      foreach (tk[i]) begin
         {ha, hb, psa, slp} <= tk[i][4:1];
         wrrd(tcq_pkg::OFF_CCFG, {19'h0, 1'h1, 9'h0, tk[i][7:5]}, 32'h0400_1007);
         window({29'h0, tk[i][0], 2'h0});
         rd(tcq_pkg::OFF_INFO, d0);
      end
      rd(tcq_pkg::OFF_TSC, d0);
      rd(tcq_pkg::OFF_TSC, d1);
      chk({24'h0, d1[7:0] - d0[7:0]}, 32'h2);
      deep <= 1'h1;
      rd(tcq_pkg::OFF_TSC, d0);
      rd(tcq_pkg::OFF_TSC, d1);
      chk({24'h0, d1[7:0] - d0[7:0]}, 32'h0);
      deep <= 1'h0;
      rd(tcq_pkg::OFF_REFCNT, d0);
      rrun <= 1'h1;
      repeat (16) @(posedge i_mclk);
      rrun <= 1'h0;
      repeat (8) @(posedge i_mclk);
      rd(tcq_pkg::OFF_REFCNT, d1);
      chk({24'h0, d1[7:0] - d0[7:0]}, 32'h2);
      wrrd(tcq_pkg::OFF_MASK, 32'h0, 32'h7);
      wrrd(tcq_pkg::OFF_CCFG, 32'h0400_1003, 32'h0400_1007);
      wrrd(tcq_pkg::OFF_CNT, 32'h0, 32'h0);
      go <= 1'h1;
      repeat (300) @(posedge i_mclk);
      go <= 1'h0;
      @(posedge i_mclk);
      chk({31'h0, o_irq}, 32'h0);
      wrrd(tcq_pkg::OFF_MASK, 32'h1, 32'h7);
      chk({31'h0, o_irq}, 32'h1);
      rd(tcq_pkg::OFF_STAT, d0);
      chk(d0 & 32'h1, 32'h1);
      chk({31'h0, o_irq}, 32'h0);
      rd(tcq_pkg::OFF_STAT, d0);
      chk(d0 & 32'h1, 32'h0);
      report_and_stop();
   end
endmodule
